// ### common/sfcs_regs.vh
/*
 * constants of the serial flash command sequencer: opcodes, status bits,
 * allocation geometry and link timing.
 * assumes inclusion by bare name from the top-level rtl file only.
 */
`ifndef SFCS_REGS_VH
`define SFCS_REGS_VH

`define SFCS_OP_READ_ID      8'h9F
`define SFCS_OP_READ_STATUS  8'h05
`define SFCS_OP_WRITE_EN     8'h06
`define SFCS_OP_CHIP_ERASE   8'hC7
`define SFCS_OP_READ_DATA    8'h03
`define SFCS_OP_PAGE_PROG    8'h02
`define SFCS_OP_SECTOR_ERASE 8'h20

`define SFCS_ST_BUSY_BIT     0
`define SFCS_ST_WEL_BIT      1

`define SFCS_ID_BYTES        4'h3
`define SFCS_ADDR_BYTES      4'h3
`define SFCS_PROG_MAX        9'h100

`define SFCS_UNIT_SHIFT      12
`define SFCS_MAX_FILES       8'h80
`define SFCS_MAX_FILE_BYTES  25'h100_0000
`define SFCS_SECURE_MIN_UNITS 13'h0002

`define SFCS_CMD_READ_ID     3'h0
`define SFCS_CMD_READ_STATUS 3'h1
`define SFCS_CMD_WRITE_EN    3'h2
`define SFCS_CMD_CHIP_ERASE  3'h3
`define SFCS_CMD_READ_DATA   3'h4
`define SFCS_CMD_PAGE_PROG   3'h5
`define SFCS_CMD_SECTOR_ERASE 3'h6
`define SFCS_CMD_ALLOC       3'h7

`define SFCS_SCK_HALF_DIV    8'h04

`endif

// ### rtl/sfcs_buf2.v
/*
 * two-entry valid/ready buffer carrying bytes toward the user.
 * assumes one clock mclk and asynchronous active-low reset.
 */
`timescale 1ns/1ps
module sfcs_buf2 #(
    parameter W = 8
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rstn,
    // fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_r [0:1];
    reg         wp_r;
    reg         rp_r;
    reg [1:0]   cnt_r;
    wire        push = in_valid && in_ready;
    wire        pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wp_r     <= 1'b0;
            rp_r     <= 1'b0;
            cnt_r    <= 2'h0;
            mem_r[0] <= {W{1'b0}};
            mem_r[1] <= {W{1'b0}};
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r        <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule

// ### rtl/sfcs_top.v
/*
 * serial flash command sequencer: runs flash command sequences over a
 * dedicated serial link and sizes file allocations in 4KB units.
 * assumes a user command port on mclk and a flash on the link pins;
 * the flash data-out pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ps
`include "sfcs_regs.vh"
module sfcs_top #(
    parameter AREA_UNITS = 13'h1000
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // command port
    input  wire        cmd_valid,
    output wire        cmd_ready,
    input  wire [2:0]  cmd_code,
    input  wire [23:0] cmd_addr,
    input  wire [24:0] cmd_len,
    input  wire        cmd_secure,
    // program data in
    input  wire        wr_valid,
    output wire        wr_ready,
    input  wire [7:0]  wr_data,
    // read data out
    output wire        rd_valid,
    input  wire        rd_ready,
    output wire [7:0]  rd_data,
    // result
    output reg         done_r,
    output reg         err_r,
    output reg  [7:0]  status_r,
    output reg  [23:0] alloc_addr_r,
    output reg  [7:0]  file_count_r,
    // flash link
    output reg         flash_csn_r,
    output reg         flash_sck_r,
    output reg         flash_mosi_r,
    input  wire        flash_miso
);
    localparam S_IDLE = 3'h0, S_OP = 3'h1, S_ADDR = 3'h2, S_WR = 3'h3;
    localparam S_RD = 3'h4, S_GAP = 3'h5, S_POLL = 3'h6, S_FIN = 3'h7;

    reg [2:0]  st_r;
    reg [2:0]  code_r;
    reg [7:0]  sh_r;
    reg [2:0]  bit_r;
    reg [1:0]  ab_r;
    reg [23:0] addr_r;
    reg [24:0] left_r;
    reg [7:0]  div_r;
    reg        phase_r;
    reg        polling_r;
    reg        miso_s1_r, miso_s2_r;
    reg [12:0] used_r;
    reg        rd_push;
    wire       rd_in_ready;

    // the command port is the only path to flash
    assign cmd_ready = (st_r == S_IDLE);
    wire byte_tick = (div_r == `SFCS_SCK_HALF_DIV);

    // units for a file of len bytes
    function [13:0] units_of;
        input [24:0] len;
        input        sec;
        reg   [13:0] u;
        begin
            u = {1'b0, len[24:12]} + {13'h0000, (len[11:0] != 12'h000)};
            if (u == 14'h0000)
                u = 14'h0001;
            if (sec)
                u = {u[12:0], 1'b0};
            if (sec && u < {1'b0, `SFCS_SECURE_MIN_UNITS})
                u = {1'b0, `SFCS_SECURE_MIN_UNITS};
            units_of = u;
        end
    endfunction

    wire [13:0] req_units = units_of(cmd_len, cmd_secure);
    wire        wr_take   = (st_r == S_WR) && wr_valid && !phase_r && div_r == 8'h00 &&
                            bit_r == 3'h0;
    assign wr_ready = wr_take;

    sfcs_buf2 #(.W(8)) u_rdbuf (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (rd_push),
        .in_ready  (rd_in_ready),
        .in_data   (sh_r),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= flash_miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= S_IDLE; code_r <= 3'h0; sh_r <= 8'h00; bit_r <= 3'h0;
            ab_r <= 2'h0; addr_r <= 24'h00_0000; left_r <= 25'h000_0000;
            div_r <= 8'h00; phase_r <= 1'b0; polling_r <= 1'b0;
            rd_push <= 1'b0; done_r <= 1'b0; err_r <= 1'b0;
            status_r <= 8'h00; alloc_addr_r <= 24'h00_0000;
            file_count_r <= 8'h00; used_r <= 13'h0000;
            flash_csn_r <= 1'b1; flash_sck_r <= 1'b0; flash_mosi_r <= 1'b0;
        end else begin
            done_r  <= 1'b0;
            rd_push <= 1'b0;
            case (st_r)
            S_IDLE: begin
                if (cmd_valid) begin
                    code_r    <= cmd_code;
                    addr_r    <= cmd_addr;
                    polling_r <= 1'b0;
                    err_r     <= 1'b0;
                    div_r     <= 8'h00;
                    phase_r   <= 1'b0;
                    bit_r     <= 3'h0;
                    case (cmd_code)
                    `SFCS_CMD_ALLOC: begin
                        if (file_count_r == `SFCS_MAX_FILES ||
                            cmd_len > `SFCS_MAX_FILE_BYTES ||
                            {1'b0, used_r} + req_units > {1'b0, AREA_UNITS}) begin
                            err_r <= 1'b1;
                        end else begin
                            alloc_addr_r <= {used_r[11:0], 12'h000};
                            used_r       <= used_r + req_units[12:0];
                            file_count_r <= file_count_r + 8'h01;
                        end
                        done_r <= 1'b1;
                    end
                    `SFCS_CMD_PAGE_PROG: begin
                        if (cmd_len == 25'h000_0000 || cmd_len >= {16'h0000, `SFCS_PROG_MAX}) begin
                            err_r  <= 1'b1;
                            done_r <= 1'b1;
                        end else begin
                            left_r <= cmd_len;
                            st_r <= S_OP; flash_csn_r <= 1'b0;
                            sh_r <= `SFCS_OP_PAGE_PROG;
                        end
                    end
                    default: begin
                        st_r        <= S_OP;
                        flash_csn_r <= 1'b0;
                        case (cmd_code)
                        `SFCS_CMD_READ_ID: begin
                            sh_r <= `SFCS_OP_READ_ID;
                            left_r <= {21'h00_0000, `SFCS_ID_BYTES};
                        end
                        `SFCS_CMD_READ_STATUS: begin
                            sh_r <= `SFCS_OP_READ_STATUS;
                            left_r <= 25'h000_0001;
                        end
                        `SFCS_CMD_WRITE_EN:     sh_r <= `SFCS_OP_WRITE_EN;
                        `SFCS_CMD_CHIP_ERASE:   sh_r <= `SFCS_OP_CHIP_ERASE;
                        `SFCS_CMD_READ_DATA: begin
                            sh_r <= `SFCS_OP_READ_DATA;
                            left_r <= cmd_len;
                        end
                        default: begin
                            // the flash clears one 4KB sector
                            sh_r <= `SFCS_OP_SECTOR_ERASE;
                            addr_r <= {cmd_addr[23:`SFCS_UNIT_SHIFT], 12'h000};
                        end
                        endcase
                    end
                    endcase
                end
            end
            S_GAP: begin
                // chip select high between polls
                flash_csn_r <= 1'b1;
                if (byte_tick) begin
                    div_r <= 8'h00; flash_csn_r <= 1'b0; st_r <= S_OP;
                    sh_r <= `SFCS_OP_READ_STATUS; left_r <= 25'h000_0001;
                end else
                    div_r <= div_r + 8'h01;
            end
            S_FIN: begin
                flash_csn_r <= 1'b1;
                st_r        <= S_IDLE;
                done_r      <= 1'b1;
            end
            default: begin
                // shift engine: one sck half period per divider wrap
                if (st_r == S_RD && left_r == 25'h000_0000) begin
                    st_r <= S_FIN;
                end else if (st_r == S_RD && !phase_r && div_r == 8'h00 && bit_r == 3'h0 &&
                             (!rd_in_ready || rd_push) && !polling_r) begin
                    div_r <= 8'h00; // receiver stalled: hold clock low
                end else if (st_r == S_WR && div_r == 8'h00 && !phase_r && bit_r == 3'h0 &&
                             !wr_valid) begin
                    div_r <= 8'h00;
                end else if (!byte_tick) begin
                    div_r <= div_r + 8'h01;
                    if (wr_take)
                        sh_r <= wr_data;
                    if (!phase_r)
                        flash_mosi_r <= sh_r[7]; // msb first, settled before rise
                end else begin
                    div_r <= 8'h00;
                    phase_r <= ~phase_r;
                    flash_sck_r <= ~phase_r;
                    if (phase_r) begin
                        sh_r  <= {sh_r[6:0], miso_s2_r};
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                            if (st_r == S_RD) begin
                                left_r <= left_r - 25'h000_0001;
                                if (polling_r) begin
                                    status_r <= {sh_r[6:0], miso_s2_r};
                                    if ((code_r == `SFCS_CMD_WRITE_EN &&
                                         !sh_r[`SFCS_ST_WEL_BIT - 1]) ||
                                        (code_r != `SFCS_CMD_WRITE_EN &&
                                         miso_s2_r == 1'b1)) begin
                                        st_r <= S_GAP;
                                        left_r <= 25'h000_0000;
                                    end else
                                        st_r <= S_FIN;
                                end else if (code_r == `SFCS_CMD_READ_DATA) begin
                                    rd_push <= 1'b1;
                                    sh_r <= {sh_r[6:0], miso_s2_r};
                                end else begin
                                    rd_push <= 1'b1;
                                    if (code_r == `SFCS_CMD_READ_STATUS)
                                        status_r <= {sh_r[6:0], miso_s2_r};
                                end
                            end else if (st_r == S_OP && polling_r) begin
                                st_r <= S_RD;
                            end else if (st_r == S_OP &&
                                         (code_r == `SFCS_CMD_READ_ID ||
                                          code_r == `SFCS_CMD_READ_STATUS)) begin
                                st_r <= S_RD;
                            end else if (st_r == S_OP &&
                                         (code_r == `SFCS_CMD_WRITE_EN ||
                                          code_r == `SFCS_CMD_CHIP_ERASE)) begin
                                st_r <= S_GAP; polling_r <= 1'b1;
                                left_r <= 25'h000_0000;
                            end else if (st_r == S_OP) begin
                                st_r <= S_ADDR; ab_r <= 2'h0;
                                sh_r <= addr_r[23:16];
                            end else if (st_r == S_ADDR) begin
                                ab_r <= ab_r + 2'h1;
                                if (ab_r == 2'h0)
                                    sh_r <= addr_r[15:8];
                                else if (ab_r == 2'h1)
                                    sh_r <= addr_r[7:0];
                                else if (code_r == `SFCS_CMD_READ_DATA)
                                    st_r <= S_RD;
                                else if (code_r == `SFCS_CMD_PAGE_PROG)
                                    st_r <= S_WR;
                                else begin
                                    st_r <= S_GAP; polling_r <= 1'b1;
                                end
                            end else if (st_r == S_WR) begin
                                left_r <= left_r - 25'h000_0001;
                                if (left_r == 25'h000_0001)
                                    st_r <= S_FIN;
                            end
                        end
                    end
                end
            end
            endcase
        end
    end
endmodule

// ### sim/sfcs_top_sva.sv
/*
 * port assertions for the serial flash command sequencer.
 * assumes binding into sfcs_top; everything runs on mclk.
 */
`timescale 1ns/1ps
module sfcs_top_chk #(
    parameter AREA_UNITS = 13'h1000
) (
    input wire        mclk,
    input wire        rstn,
    input wire        cmd_valid,
    input wire        cmd_ready,
    input wire [2:0]  cmd_code,
    input wire [24:0] cmd_len,
    input wire        cmd_secure,
    input wire        done_r,
    input wire        err_r,
    input wire [23:0] alloc_addr_r,
    input wire [7:0]  file_count_r,
    input wire        flash_csn_r,
    input wire        flash_sck_r,
    input wire        flash_mosi_r,
    input wire        rd_valid,
    input wire        rd_ready
);
    wire take = cmd_valid && cmd_ready;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_frame_busy: assert property (!flash_csn_r |-> !cmd_ready)
        else $error("command port ready inside a frame");
    chk_sck_idle: assert property (flash_csn_r |-> !flash_sck_r)
        else $error("link clock high outside a frame");
    chk_sck_half: assert property ($rose(flash_sck_r) |-> flash_sck_r[*5] ##1 !flash_sck_r)
        else $error("link clock high phase not five cycles");
    chk_mosi_hold: assert property ($rose(flash_sck_r) |-> $stable(flash_mosi_r))
        else $error("data out moved on the sampling edge");
    chk_prog_refuse: assert property (take && cmd_code == 3'h5 &&
        (cmd_len == 25'h000_0000 || cmd_len > 25'h000_00FF) |=> done_r && err_r)
        else $error("bad program length not refused");
    chk_alloc_large: assert property (take && cmd_code == 3'h7 &&
        cmd_len > 25'h100_0000 |=> done_r && err_r)
        else $error("oversized file not refused");
    chk_alloc_align: assert property ($changed(alloc_addr_r) |-> alloc_addr_r[11:0] == 12'h000
        && {8'h00, alloc_addr_r} < (AREA_UNITS << 12))
        else $error("allocation start misaligned or outside area");
    chk_count_step: assert property ($changed(file_count_r) |->
        file_count_r == $past(file_count_r) + 8'h01)
        else $error("file count moved by other than one");
    chk_file_cap: assert property (file_count_r <= 8'h80)
        else $error("file count above limit");
    cover property (done_r && err_r);
    cover property (rd_valid && !rd_ready);
    cover property (take && cmd_code == 3'h7 && cmd_secure);
endmodule

bind sfcs_top sfcs_top_chk #(.AREA_UNITS(AREA_UNITS)) u_chk (.mclk(mclk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_len(cmd_len),
    .cmd_secure(cmd_secure), .done_r(done_r), .err_r(err_r), .alloc_addr_r(alloc_addr_r),
    .file_count_r(file_count_r), .flash_csn_r(flash_csn_r), .flash_sck_r(flash_sck_r),
    .flash_mosi_r(flash_mosi_r), .rd_valid(rd_valid), .rd_ready(rd_ready));

// ### sim/sfcs_flash_model.sv
/*
 * behavioural external serial flash, mode 0, small array.
 * assumes the sequencer drives chip select, link clock and data in.
 */
`timescale 1ns/1ps
module sfcs_flash_model #(
    parameter [23:0] ID    = 24'h5A_6117,
    parameter        POLLS = 3
) (
    input  wire csn,
    input  wire sck,
    input  wire mosi,
    output reg  miso
);
    reg [7:0]  mem [0:255];
    reg [7:0]  sh, tx, op;
    reg [23:0] addr;
    reg        wel;
    integer    bits, busy_n, k;
    initial begin
        {miso, wel, sh, tx, op, addr} = 50'h0;
        bits = 0;
        busy_n = 0;
        for (k = 0; k < 256; k = k + 1) mem[k] = 8'hFF;
    end
    always @(negedge csn) bits = 0;
    // released line shows the inverse, never a stale bit
    always @(posedge csn) begin
        miso = ~miso;
        if (op == 8'h02 || op == 8'h20 || op == 8'hC7) wel = 1'b0;
    end
    always @(posedge sck) if (!csn) begin
        sh = {sh[6:0], mosi};
        bits = bits + 1;
        if (bits == 8) begin
            op = sh;
            if (op == 8'h06) wel = 1'b1;
            if (op == 8'hC7 && wel) busy_n = POLLS;
        end else if (bits % 8 == 0 && bits <= 32 && (op == 8'h02 || op == 8'h03 || op == 8'h20))
            addr = {addr[15:0], sh};
        else if (bits % 8 == 0 && op == 8'h02 && wel) mem[addr[7:0] + bits / 8 - 5] = sh;
        if (bits == 32 && op == 8'h20 && wel) begin
            busy_n = POLLS;
            for (k = 0; k < 256; k = k + 1) mem[k] = 8'hFF;
        end
    end
    always @(negedge sck) if (!csn && bits > 0) begin
        if (bits % 8 == 0) begin
            if (op == 8'h9F) tx = ID >> (8 * (3 - bits / 8));
            else if (op == 8'h05) begin
                tx = {6'h00, wel, busy_n != 0};
                if (busy_n > 0) busy_n = busy_n - 1;
            end else if (op == 8'h03 && bits >= 32) tx = mem[addr[7:0] + bits / 8 - 4];
        end
        miso = tx[7 - bits % 8];
    end
endmodule

// ### sim/sfcs_top_tb.sv
/*
 * self-checking bench: sequencer against the behavioural flash.
 * assumes the rtl, the checker and the flash model compile first.
 */
`timescale 1ns/1ps
module sfcs_top_tb;
    localparam [23:0] FL_ID = 24'h5A_6117; // arbitrary identity value
    reg         mclk, rstn, cmd_valid, cmd_secure, wr_valid, rd_ready, stall;
    reg  [2:0]  cmd_code;
    reg  [23:0] cmd_addr;
    reg  [24:0] cmd_len;
    reg  [7:0]  wr_data;
    reg  [7:0]  wq[$], rxq[$];
    wire        cmd_ready, wr_ready, rd_valid, done_r, err_r, csn, sck, mosi, miso;
    wire [7:0]  rd_data, status_r, file_count_r;
    wire [23:0] alloc_addr_r;
    integer     errors, n_tests;
    sfcs_top #(.AREA_UNITS(13'h0008)) dut (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .cmd_secure(cmd_secure), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .done_r(done_r),
        .err_r(err_r), .status_r(status_r), .alloc_addr_r(alloc_addr_r),
        .file_count_r(file_count_r), .flash_csn_r(csn), .flash_sck_r(sck),
        .flash_mosi_r(mosi), .flash_miso(miso));
    sfcs_flash_model #(.ID(FL_ID), .POLLS(3)) fl (.csn(csn), .sck(sck), .mosi(mosi),
        .miso(miso));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // byte source and sink; a popped byte is replaced after the edge
    always @(posedge mclk) begin
        if (rd_valid && rd_ready) rxq.push_back(rd_data);
        if (wr_valid && wr_ready) void'(wq.pop_front());
        rd_ready <= !stall;
        wr_valid <= wq.size() != 0;
        wr_data  <= wq.size() != 0 ? wq[0] : 8'h00;
    end
    task print_verdict;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input [2:0] c, input [23:0] a, input [24:0] l, input s);
        integer i;
        rxq.delete();
        {cmd_code, cmd_addr, cmd_len, cmd_secure, cmd_valid} <= {c, a, l, s, 1'b1};
        @(posedge mclk);
        cmd_valid <= 1'b0;
        i = 0;
        while (done_r !== 1'b1 && i < 30000) begin
            @(negedge mclk);
            i = i + 1;
        end
        if (i >= 30000) begin
            errors = errors + 1;
            disable main_seq;
        end
        @(posedge mclk);
    endtask
    task t_status(input [7:0] exp);
        run(3'h1, 24'h00_0000, 25'h000_0000, 1'b0);
        chk(rxq.size(), 1);
        chk(rxq[0], exp);
        chk(status_r, exp);
    endtask
    task t_flash;
        run(3'h0, 24'h00_0000, 25'h000_0000, 1'b0);
        chk(rxq.size(), 3);
        chk({rxq[0], rxq[1], rxq[2]}, FL_ID);
        chk(fl.op, 8'h9F);
        t_status(8'h00);
        run(3'h2, 24'h00_0000, 25'h000_0000, 1'b0);
        chk(status_r[1], 1'b1);
        chk(fl.op, 8'h05);
        t_status(8'h02);
        run(3'h3, 24'h00_0000, 25'h000_0000, 1'b0);
        chk(fl.busy_n, 0);
        chk(status_r, 8'h00);
    endtask
    task t_prog_read;
        run(3'h2, 24'h00_0000, 25'h000_0000, 1'b0);
        wq = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
        run(3'h5, 24'h00_1010, 25'h000_0004, 1'b0);
        chk(err_r, 1'b0);
        chk(wq.size(), 0);
        chk(fl.addr, 24'h00_1010);
        chk({fl.mem[16], fl.mem[17], fl.mem[18], fl.mem[19]}, 32'hA53C_0FF0);
        run(3'h5, 24'h00_0000, 25'h000_0000, 1'b0);
        chk(err_r, 1'b1);
        run(3'h5, 24'h00_0000, 25'h000_0100, 1'b0);
        chk(err_r, 1'b1);
        stall <= 1'b1;
        fork
            run(3'h4, 24'h00_1010, 25'h000_0004, 1'b0);
            begin
                repeat (1500) @(posedge mclk);
                stall <= 1'b0;
            end
        join
        chk(rxq.size(), 4);
        chk({rxq[0], rxq[1], rxq[2], rxq[3]}, 32'hA53C_0FF0);
        chk({fl.op, fl.addr}, 32'h0300_1010);
        run(3'h2, 24'h00_0000, 25'h000_0000, 1'b0);
        run(3'h6, 24'h00_1FFF, 25'h000_0000, 1'b0);
        chk(fl.addr, 24'h00_1000);
        chk(fl.busy_n, 0);
        chk(fl.mem[16], 8'hFF);
    endtask
    task t_alloc;
        run(3'h7, 24'h00_0000, 25'h000_0001, 1'b0);
        chk(alloc_addr_r, 24'h00_0000);
        chk(file_count_r, 8'h01);
        run(3'h7, 24'h00_0000, 25'h000_2000, 1'b1);
        chk(alloc_addr_r, 24'h00_1000);
        run(3'h7, 24'h00_0000, 25'h000_0001, 1'b1);
        chk(alloc_addr_r, 24'h00_5000);
        run(3'h7, 24'h00_0000, 25'h000_1001, 1'b0);
        chk(err_r, 1'b1);
        run(3'h7, 24'h00_0000, 25'h100_0001, 1'b0);
        chk(err_r, 1'b1);
        run(3'h7, 24'h00_0000, 25'h000_0001, 1'b0);
        chk(alloc_addr_r, 24'h00_7000);
        chk(file_count_r, 8'h04);
    endtask
    initial begin
        errors = 0;
        n_tests = 0;
        {rstn, cmd_valid, cmd_secure, wr_valid, rd_ready, stall} = 6'h02;
        {cmd_code, cmd_addr, cmd_len, wr_data} = 60'h0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        begin : main_seq
            t_flash;
            t_prog_read;
            t_alloc;
        end
        print_verdict;
    end
endmodule
